// ### rtl/aot_pkg.sv
// Constants, types and address decode shared by the offset trim bank
`default_nettype none

package aot_pkg;

    localparam int AW    = 12;
    localparam int DW    = 16;
    localparam int TW    = 12;
    localparam int NTRIM = 6;

    typedef logic [TW-1:0] aot_trim_t;
    typedef logic [2:0]    aot_idx_t;

    localparam logic [AW-1:0] ADDR_CORE0  = 12'h330;
    localparam logic [AW-1:0] ADDR_CORE1  = 12'h332;
    localparam logic [AW-1:0] ADDR_CORE2A = 12'h334;
    localparam logic [AW-1:0] ADDR_CORE2B = 12'h336;
    localparam logic [AW-1:0] ADDR_CORE3C = 12'h338;
    localparam logic [AW-1:0] ADDR_CORE3D = 12'h33A;
    localparam logic [AW-1:0] ADDR_CTRL   = 12'h350;
    localparam logic [AW-1:0] ADDR_STAT   = 12'h352;

    localparam aot_idx_t IDX_CORE0  = 3'h0;
    localparam aot_idx_t IDX_CORE1  = 3'h1;
    localparam aot_idx_t IDX_CORE2A = 3'h2;
    localparam aot_idx_t IDX_CORE2B = 3'h3;
    localparam aot_idx_t IDX_CORE3C = 3'h4;
    localparam aot_idx_t IDX_CORE3D = 3'h5;

    localparam aot_trim_t       TRIM_RST  = 12'h000;
    localparam logic [DW-TW-1:0] RSVD_RD  = 4'h0;
    localparam logic [DW-1:0]   RD_IDLE   = 16'h0000;
    localparam logic [2:0]      CTRL_RST  = 3'h0;

    // Control register bit positions
    localparam int CTL_OFS  = 0;
    localparam int CTL_BG   = 1;
    localparam int CTL_BGOS = 2;
    // Status register bit positions
    localparam int ST_FG    = 0;
    localparam int ST_BUSY  = 1;
    localparam int ST_OK    = 2;
    localparam int ST_VIOL  = 3;

    function automatic logic aot_trim_hit(input logic [AW-1:0] a);
        return (a >= ADDR_CORE0) && (a <= ADDR_CORE3D) && !a[0];
    endfunction

    function automatic aot_idx_t aot_trim_idx(input logic [AW-1:0] a);
        logic [AW-1:0] d;
        d = a - ADDR_CORE0;
        return d[3:1];
    endfunction

endpackage

`default_nettype wire

// ### rtl/aot_trim_store.sv
// Storage for the six offset trim words, written by software or fuse load
`default_nettype none

module aot_trim_store
    import aot_pkg::*;
(
    input  wire logic                       mclk_i,
    input  wire logic                       rst_i,
    input  wire logic                       wr_i,
    input  wire aot_pkg::aot_idx_t          wr_idx_i,
    input  wire aot_pkg::aot_trim_t         wr_data_i,
    input  wire logic                       ld_i,
    input  wire aot_pkg::aot_idx_t          ld_idx_i,
    input  wire aot_pkg::aot_trim_t         ld_data_i,
    output logic [aot_pkg::NTRIM-1:0][aot_pkg::TW-1:0] trim_o
);

    import aot_pkg::*;

    logic [NTRIM-1:0][TW-1:0] trim_q;

    // Software write takes priority over a fuse load of the same word
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            trim_q <= {NTRIM{TRIM_RST}};
        end else begin
            for (int i = 0; i < NTRIM; i++) begin
                if (wr_i && wr_idx_i == aot_idx_t'(i)) begin
                    trim_q[i] <= wr_data_i;
                end else if (ld_i && ld_idx_i == aot_idx_t'(i)) begin
                    trim_q[i] <= ld_data_i;
                end
            end
        end
    end

    assign trim_o = trim_q;

    chk_fuse_load: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ld_i && !(wr_i && wr_idx_i == ld_idx_i) && ld_idx_i < aot_idx_t'(NTRIM)
        |=> trim_q[$past(ld_idx_i)] == $past(ld_data_i)
    ) else $error("fuse load did not reach trim word");

endmodule

`default_nettype wire

// ### rtl/aot_trim_bank.sv
// Offset trim register bank with calibration access guard and core outputs
// Function
// - Core 0 trim is the low 12 bits and drives core 0 offset.
// - Every trim field is treated as an unsigned binary number.
// - Background without continuous offset still trims spare cores in foreground.
// - Outside restricted cases trim accesses are taken at once.
// - Trim at 0x332 drives core 1 offset.
// - Core 2 uses 0x334 on pair A, 0x336 on pair B.
// - Core 3 uses 0x338 on pair C, 0x33A on pair D.
// - Trim defaults load from factory fuse storage.
//
// Design decision made here: the address-and-strobe port.
`default_nettype none

module aot_trim_bank
    import aot_pkg::*;
(
    input  wire logic                   mclk_i,
    input  wire logic                   rst_i,
    input  wire logic [aot_pkg::AW-1:0] addr_i,
    input  wire logic [aot_pkg::DW-1:0] wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic [aot_pkg::DW-1:0]      rdata_o,
    input  wire logic                   fuse_load_i,
    input  wire aot_pkg::aot_idx_t      fuse_idx_i,
    input  wire aot_pkg::aot_trim_t     fuse_data_i,
    input  wire logic                   fg_cal_done_i,
    input  wire logic                   ofs_cal_busy_i,
    input  wire logic                   pair_b_sel_i,
    input  wire logic                   pair_d_sel_i,
    output aot_pkg::aot_trim_t          core0_trim_o,
    output aot_pkg::aot_trim_t          core1_trim_o,
    output aot_pkg::aot_trim_t          core2_trim_o,
    output aot_pkg::aot_trim_t          core3_trim_o,
    output logic                        cont_ofs_cal_o,
    output logic                        spare_fg_ofs_cal_o,
    output logic                        access_ok_o
);

    import aot_pkg::*;

    // Storage and decode
    logic [NTRIM-1:0][TW-1:0] trim;
    logic                     trim_hit;
    aot_idx_t                 trim_idx;
    logic                     ctrl_hit;
    logic                     stat_hit;
    logic                     trim_wr;
    logic                     trim_acc;

    assign trim_hit = aot_trim_hit(addr_i);
    assign trim_idx = aot_trim_idx(addr_i);
    assign ctrl_hit = (addr_i == ADDR_CTRL);
    assign stat_hit = (addr_i == ADDR_STAT);
    assign trim_wr  = wr_i && trim_hit;
    assign trim_acc = (wr_i || rd_i) && trim_hit;

    // Reserved upper bits are dropped on write
    aot_trim_store u_store (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .wr_i      (trim_wr),
        .wr_idx_i  (trim_idx),
        .wr_data_i (wdata_i[TW-1:0]),
        .ld_i      (fuse_load_i),
        .ld_idx_i  (fuse_idx_i),
        .ld_data_i (fuse_data_i),
        .trim_o    (trim)
    );

    // Calibration control
    logic [2:0] ctrl_q;
    logic [2:0] ctrl_d;
    logic       ofs_en;
    logic       bg_en;
    logic       bgos_en;

    assign ctrl_d  = (wr_i && ctrl_hit) ? wdata_i[2:0] : ctrl_q;
    assign ofs_en  = ctrl_q[CTL_OFS];
    assign bg_en   = ctrl_q[CTL_BG];
    assign bgos_en = ctrl_q[CTL_BGOS];

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Access window for trim registers
    logic full_bg;
    logic fg_wait;
    logic acc_ok;

    assign full_bg = bg_en && bgos_en;
    assign fg_wait = ofs_en && !full_bg && !fg_cal_done_i;
    assign acc_ok  = !ofs_cal_busy_i && !full_bg && !fg_wait;

    // Sticky flag for accesses made outside the window; a new event wins
    logic viol_q;
    logic viol_d;
    logic viol_set;
    logic viol_clr;

    assign viol_set = trim_acc && !acc_ok;
    assign viol_clr = wr_i && stat_hit && wdata_i[ST_VIOL];
    assign viol_d   = viol_set ? 1'b1 : (viol_clr ? 1'b0 : viol_q);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            viol_q <= 1'b0;
        end else begin
            viol_q <= viol_d;
        end
    end

    // Calibration mode outputs
    logic cont_d;
    logic spare_d;
    logic cont_q;
    logic spare_q;
    logic ok_q;

    assign cont_d  = ofs_en && full_bg;
    assign spare_d = ofs_en && bg_en;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cont_q  <= 1'b0;
            spare_q <= 1'b0;
            ok_q    <= 1'b0;
        end else begin
            cont_q  <= cont_d;
            spare_q <= spare_d;
            ok_q    <= acc_ok;
        end
    end

    assign cont_ofs_cal_o     = cont_q;
    assign spare_fg_ofs_cal_o = spare_q;
    assign access_ok_o        = ok_q;

    // Per-core trim selection, all unsigned
    aot_trim_t c0_d;
    aot_trim_t c1_d;
    aot_trim_t c2_d;
    aot_trim_t c3_d;
    aot_trim_t c0_q;
    aot_trim_t c1_q;
    aot_trim_t c2_q;
    aot_trim_t c3_q;

    assign c0_d = trim[IDX_CORE0];
    assign c1_d = trim[IDX_CORE1];
    assign c2_d = pair_b_sel_i ? trim[IDX_CORE2B] : trim[IDX_CORE2A];
    assign c3_d = pair_d_sel_i ? trim[IDX_CORE3D] : trim[IDX_CORE3C];

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            c0_q <= TRIM_RST;
            c1_q <= TRIM_RST;
            c2_q <= TRIM_RST;
            c3_q <= TRIM_RST;
        end else begin
            c0_q <= c0_d;
            c1_q <= c1_d;
            c2_q <= c2_d;
            c3_q <= c3_d;
        end
    end

    assign core0_trim_o = c0_q;
    assign core1_trim_o = c1_q;
    assign core2_trim_o = c2_q;
    assign core3_trim_o = c3_q;

    // Read path: data stand only in the cycle after the strobe
    logic [DW-1:0] stat_word;
    logic [DW-1:0] ctrl_word;
    logic [DW-1:0] trim_word;
    logic [DW-1:0] rd_sel;
    logic [DW-1:0] rdata_d;
    logic [DW-1:0] rdata_q;

    assign stat_word = {12'h000, viol_q, acc_ok, ofs_cal_busy_i, fg_cal_done_i};
    assign ctrl_word = {13'h0, ctrl_q};
    assign trim_word = {RSVD_RD, trim[trim_idx]};
    assign rd_sel    = trim_hit ? trim_word :
                       ctrl_hit ? ctrl_word :
                       stat_hit ? stat_word : RD_IDLE;
    assign rdata_d   = rd_i ? rd_sel : RD_IDLE;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= RD_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    // Checks

    chk_read_idle_zero: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !rd_i |=> rdata_o == RD_IDLE
    ) else $error("read data not zero outside read reply");

    chk_trim_read_back: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        rd_i && trim_hit
        |=> rdata_o == {RSVD_RD, $past(trim[trim_idx])}
    ) else $error("trim read did not return stored value");

    chk_write_then_read: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr_i && trim_hit ##1 rd_i && $past(addr_i) == addr_i
        |=> rdata_o[TW-1:0] == $past(wdata_i[TW-1:0], 2)
    ) else $error("written trim not read back");

    chk_resv_read_zero: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        $past(rd_i) && $past(trim_hit) |-> rdata_o[DW-1:TW] == RSVD_RD
    ) else $error("reserved trim bits read non-zero");

    chk_core0_core1: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ##1 (core0_trim_o == $past(trim[IDX_CORE0]))
            && (core1_trim_o == $past(trim[IDX_CORE1]))
    ) else $error("core 0 or 1 trim output wrong");

    chk_core2_pair: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        pair_b_sel_i |=> core2_trim_o == $past(trim[IDX_CORE2B])
    ) else $error("core 2 pair B trim not applied");

    chk_core2_pair_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !pair_b_sel_i |=> core2_trim_o == $past(trim[IDX_CORE2A])
    ) else $error("core 2 pair A trim not applied");

    chk_core3_pair: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ##1 core3_trim_o == ($past(pair_d_sel_i) ? $past(trim[IDX_CORE3D])
                                                 : $past(trim[IDX_CORE3C]))
    ) else $error("core 3 trim selection wrong");

    chk_bg_no_cont: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ofs_en && bg_en && !bgos_en |=> !cont_ofs_cal_o && spare_fg_ofs_cal_o
    ) else $error("background without continuous offset misbehaves");

    chk_access_open: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !ofs_cal_busy_i && !(bg_en && bgos_en) && (!ofs_en || fg_cal_done_i)
        |=> access_ok_o
    ) else $error("access window closed without cause");

    chk_access_shut: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (bg_en && bgos_en) || (ofs_en && !fg_cal_done_i) || ofs_cal_busy_i
        |=> !access_ok_o
    ) else $error("access window open during calibration");

    chk_viol_sticky: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        trim_acc && !acc_ok |=> viol_q [*2]
    ) else $error("restricted access not flagged");

    chk_viol_clear: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        viol_clr && !viol_set |=> !viol_q
    ) else $error("violation flag not cleared by write of one");

    chk_viol_hold: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !viol_set && !viol_clr |=> viol_q == $past(viol_q)
    ) else $error("violation flag changed without cause");

    chk_stat_read: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        rd_i && stat_hit
        |=> rdata_o[ST_FG] == $past(fg_cal_done_i)
            && rdata_o[ST_BUSY] == $past(ofs_cal_busy_i)
            && rdata_o[ST_VIOL] == $past(viol_q)
    ) else $error("status read does not match live state");

    chk_ctrl_write: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr_i && ctrl_hit |=> ctrl_q == $past(wdata_i[2:0])
    ) else $error("control write not stored");

    chk_ctrl_read: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        rd_i && ctrl_hit |=> rdata_o == {13'h0, $past(ctrl_q)}
    ) else $error("control read does not return stored enables");

    chk_cont_off: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !(ofs_en && bg_en && bgos_en) |=> !cont_ofs_cal_o
    ) else $error("continuous offset cal runs without all enables");

    chk_cont_on: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ofs_en && bg_en && bgos_en |=> cont_ofs_cal_o
    ) else $error("continuous offset cal not started");

    chk_spare_off: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !(ofs_en && bg_en) |=> !spare_fg_ofs_cal_o
    ) else $error("spare core trim requested without background cal");

    chk_spare_on: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ofs_en && bg_en |=> spare_fg_ofs_cal_o
    ) else $error("spare core trim not requested");

    chk_unmapped_read: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        rd_i && !trim_hit && !ctrl_hit && !stat_hit |=> rdata_o == RD_IDLE
    ) else $error("unmapped read returned non-zero");

    chk_trim_write: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        trim_wr |=> trim[$past(trim_idx)] == $past(wdata_i[TW-1:0])
    ) else $error("software write did not reach trim word");

endmodule

`default_nettype wire

// ### dv/aot_trim_bank_tb_top.sv
// Self-checking bench for the offset trim register bank
`default_nettype none

module aot_trim_bank_tb_top
    import aot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          mclk_i;
    logic          rst_i;
    logic [AW-1:0] addr_i;
    logic [DW-1:0] wdata_i;
    logic          wr_i;
    logic          rd_i;
    logic [DW-1:0] rdata_o;
    logic          fuse_load_i;
    aot_idx_t      fuse_idx_i;
    aot_trim_t     fuse_data_i;
    logic          fg_cal_done_i;
    logic          ofs_cal_busy_i;
    logic          pair_b_sel_i;
    logic          pair_d_sel_i;
    aot_trim_t     core0_trim_o;
    aot_trim_t     core1_trim_o;
    aot_trim_t     core2_trim_o;
    aot_trim_t     core3_trim_o;
    logic          cont_ofs_cal_o;
    logic          spare_fg_ofs_cal_o;
    logic          access_ok_o;
    int            n_fail;
    int            checks;
    aot_trim_t     exp_trim [NTRIM];
    logic [DW-1:0] rd_val;
    logic [2:0]    cv;
    logic          ok;

    aot_trim_bank dut_u (
        .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fuse_load_i(fuse_load_i),
        .fuse_idx_i(fuse_idx_i), .fuse_data_i(fuse_data_i), .fg_cal_done_i(fg_cal_done_i),
        .ofs_cal_busy_i(ofs_cal_busy_i), .pair_b_sel_i(pair_b_sel_i),
        .pair_d_sel_i(pair_d_sel_i), .core0_trim_o(core0_trim_o),
        .core1_trim_o(core1_trim_o), .core2_trim_o(core2_trim_o),
        .core3_trim_o(core3_trim_o), .cont_ofs_cal_o(cont_ofs_cal_o),
        .spare_fg_ofs_cal_o(spare_fg_ofs_cal_o), .access_ok_o(access_ok_o)
    );

    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    task automatic cmp_word(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic bus_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe edge
    task automatic bus_rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    // Write, then read back on the very next edge with no idle cycle
    task automatic bus_wr_rd(input logic [AW-1:0] a, input logic [DW-1:0] d,
                             output logic [DW-1:0] q);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        q = rdata_o;
    endtask

    task automatic fuse_ld(input aot_idx_t i, input aot_trim_t d);
        @(posedge mclk_i);
        fuse_load_i <= 1'b1;
        fuse_idx_i  <= i;
        fuse_data_i <= d;
        @(posedge mclk_i);
        fuse_load_i <= 1'b0;
    endtask

    // Reads every word back, then checks what each core is given
    task automatic chk_all();
        for (int i = 0; i < NTRIM; i++) begin
            bus_rd(ADDR_CORE0 + AW'(2 * i), rd_val);
            cmp_word("trim_read", {4'h0, exp_trim[i]}, rd_val);
        end
        repeat (2) @(posedge mclk_i);
        #1;
        cmp_word("core0", {4'h0, exp_trim[0]}, {4'h0, core0_trim_o});
        cmp_word("core1", {4'h0, exp_trim[1]}, {4'h0, core1_trim_o});
        cmp_word("core2", {4'h0, pair_b_sel_i ? exp_trim[3] : exp_trim[2]}, {4'h0, core2_trim_o});
        cmp_word("core3", {4'h0, pair_d_sel_i ? exp_trim[5] : exp_trim[4]}, {4'h0, core3_trim_o});
    endtask

    task automatic final_report();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        n_fail++;
        $display("[FAIL] watchdog expected finish seen timeout");
        final_report();
    end

    initial begin
        rst_i = 1'b1;
        addr_i = '0;
        wdata_i = '0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        fuse_load_i = 1'b0;
        fuse_idx_i = IDX_CORE0;
        fuse_data_i = TRIM_RST;
        fg_cal_done_i = 1'b0;
        ofs_cal_busy_i = 1'b0;
        pair_b_sel_i = 1'b0;
        pair_d_sel_i = 1'b0;
        n_fail = 0;
        checks = 0;
        foreach (exp_trim[i]) exp_trim[i] = TRIM_RST;
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        chk_all();
        cmp_bit("cont", 1'b0, cont_ofs_cal_o);
        for (int i = 0; i < NTRIM; i++) begin
            exp_trim[i] = 12'h0A0 + TW'(i);
            fuse_ld(aot_idx_t'(i), exp_trim[i]);
        end
        fuse_ld(3'h6, 12'hFFF);
        chk_all();
        // Full-scale value must stay positive; reserved bits are written as zero
        bus_wr(ADDR_CORE0, 16'h0FFF);
        bus_wr(ADDR_CORE1, 16'h0123);
        bus_wr(ADDR_CORE2A, 16'h0456);
        bus_wr(ADDR_CORE2B, 16'h0789);
        bus_wr(ADDR_CORE3C, 16'h0ABC);
        bus_wr(ADDR_CORE3D, 16'h0DEF);
        exp_trim = '{12'hFFF, 12'h123, 12'h456, 12'h789, 12'hABC, 12'hDEF};
        chk_all();
        @(posedge mclk_i);
        pair_b_sel_i <= 1'b1;
        pair_d_sel_i <= 1'b1;
        chk_all();
        @(posedge mclk_i);
        #1;
        cmp_word("rd_idle", RD_IDLE, rdata_o);
        bus_wr(12'h331, 16'h0FFF);
        bus_rd(12'h331, rd_val);
        cmp_word("unmapped", RD_IDLE, rd_val);
        bus_wr_rd(ADDR_CORE3C, 16'h0321, rd_val);
        cmp_word("wr_rd", 16'h0321, rd_val);
        exp_trim[4] = 12'h321;
        // Software write wins over a fuse load to the same word
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= ADDR_CORE2A;
        wdata_i <= 16'h0555;
        fuse_load_i <= 1'b1;
        fuse_idx_i <= IDX_CORE2A;
        fuse_data_i <= 12'hAAA;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        fuse_load_i <= 1'b0;
        exp_trim[2] = 12'h555;
        chk_all();
        for (int c = 0; c < 8; c++) begin
            for (int b = 0; b < 2; b++) begin
                for (int f = 0; f < 2; f++) begin
                    cv = 3'(c);
                    bus_wr(ADDR_CTRL, {13'h0, cv});
                    @(posedge mclk_i);
                    ofs_cal_busy_i <= 1'(b);
                    fg_cal_done_i <= 1'(f);
                    repeat (2) @(posedge mclk_i);
                    #1;
                    ok = (b == 0) && !(cv[1] && cv[2]) && !(cv[0] && f == 0);
                    cmp_bit("access_ok", ok, access_ok_o);
                    cmp_bit("cont", &cv, cont_ofs_cal_o);
                    cmp_bit("spare", cv[0] & cv[1], spare_fg_ofs_cal_o);
                    bus_rd(ADDR_STAT, rd_val);
                    cmp_word("stat", {12'h0, 1'b0, ok, 1'(b), 1'(f)}, {12'h0, rd_val[3:0]});
                    bus_rd(ADDR_CTRL, rd_val);
                    cmp_word("ctrl", {13'h0, cv}, rd_val);
                end
            end
        end
        bus_wr(ADDR_CTRL, 16'h0000);
        @(posedge mclk_i);
        fg_cal_done_i <= 1'b0;
        // Access during calibration is still served but flagged
        bus_rd(ADDR_CORE1, rd_val);
        cmp_word("trim_busy", {4'h0, exp_trim[1]}, rd_val);
        bus_rd(ADDR_STAT, rd_val);
        cmp_bit("viol_set", 1'b1, rd_val[3]);
        @(posedge mclk_i);
        ofs_cal_busy_i <= 1'b0;
        bus_wr(ADDR_STAT, 16'h0008);
        bus_rd(ADDR_STAT, rd_val);
        cmp_word("viol_clr", 16'h0004, {12'h0, rd_val[3:0]});
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        foreach (exp_trim[i]) exp_trim[i] = TRIM_RST;
        chk_all();
        final_report();
    end
endmodule

`default_nettype wire
